// ==== periph_port_side.sv ====
// peripheral port master: lane select, write flag, clock and reset forwarding
`timescale 1ns/1ps
`include "periph_port_map.svh"
module periph_port_side
    import periph_port_pkg::*;
#(
    parameter bit BREAK_ON_HARD_RESET = 1'b0,
    parameter bit HAS_MULDIV_UNIT     = 1'b1
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire periph_req_s req,
    input  wire logic        req_valid,
    output logic             req_ready,
    output logic             done,
    output logic [31:0]      rdata,
    input  wire logic        breakpoint_hit,
    output logic             halted,
    output logic             muldiv_present,
    output logic             periph_clock_out,
    output logic             periph_reset_out,
    output logic             periph_cycle_out,
    output logic             periph_strobe_out,
    output logic [23:0]      periph_addr_out,
    output logic [31:0]      periph_write_data,
    output logic [3:0]       periph_byte_select,
    output logic             periph_write_flag,
    input  wire logic        periph_ack_in,
    input  wire logic [31:0] periph_read_data
);
    typedef enum logic [0:0] {st_idle, st_busy} bus_st_e;
    bus_st_e st_r;

    // lane select from size and low address bits
    logic [3:0] sel_nxt;
    wire  [3:0] sel_half = req.addr[1] ? `SEL_HALF_HI : `SEL_HALF_LO;
    wire  [3:0] sel_byte = 4'(`SEL_BYTE_ONE << req.addr[1:0]);
    always_comb begin
        unique case (req.size)
            size_byte: sel_nxt = sel_byte;
            size_half: sel_nxt = sel_half;
            size_word: sel_nxt = `SEL_WORD;
            size_bad:  sel_nxt = `SEL_NONE;
        endcase
    end

    wire start     = req_valid && (st_r == st_idle) && !periph_reset_out;
    wire ack_taken = (st_r == st_busy) && periph_ack_in;
    assign req_ready = (st_r == st_idle) && !periph_reset_out;

    // forwarded clock is the system clock itself
    assign periph_clock_out = clk_sys;
    assign muldiv_present   = HAS_MULDIV_UNIT;

    // forwarded reset follows the external reset, released one edge later
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            periph_reset_out <= 1'b1;
        end else begin
            periph_reset_out <= 1'b0;
        end
    end

    // halt on first breakpoint after a hard reset, if enabled
    logic armed_r;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            armed_r <= 1'b1;
            halted  <= 1'b0;
        end else if (armed_r && breakpoint_hit) begin
            armed_r <= 1'b0;
            halted  <= BREAK_ON_HARD_RESET;
        end
    end

    // next bus state: open on a taken request, close on slave ack
    bus_st_e st_nxt;
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            st_idle: if (start) st_nxt = st_busy;
            st_busy: if (periph_ack_in) st_nxt = st_idle;
        endcase
    end

    // bus cycle state register: cycle held until slave ack
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_r <= st_idle;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign periph_cycle_out  = (st_r == st_busy);
    assign periph_strobe_out = (st_r == st_busy);

    // bus outputs latched at cycle start
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            periph_addr_out    <= '0;
            periph_write_data  <= '0;
            periph_byte_select <= `SEL_NONE;
            periph_write_flag  <= 1'b0;
        end else if (start) begin
            periph_addr_out    <= req.addr;
            periph_write_data  <= req.wdata;
            periph_byte_select <= sel_nxt;
            periph_write_flag  <= req.write;
        end
    end

    // read data sampled on ack, done pulse
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rdata <= '0;
            done  <= 1'b0;
        end else begin
            done <= ack_taken;
            if (ack_taken && !periph_write_flag) begin
                rdata <= periph_read_data;
            end
        end
    end

    // checks on cycle framing, lanes, write flag, reset and halt
    property p_cycle_held;
        @(posedge clk_sys) disable iff (reset)
        periph_cycle_out && !periph_ack_in |=> periph_cycle_out;
    endproperty
    a_cycle_held: assert property (p_cycle_held)
        else $error("cycle dropped before ack");

    property p_ack_ends;
        @(posedge clk_sys) disable iff (reset)
        periph_cycle_out && periph_ack_in |=> !periph_cycle_out && done;
    endproperty
    a_ack_ends: assert property (p_ack_ends)
        else $error("ack did not end cycle");

    property p_done_pulse;
        @(posedge clk_sys) disable iff (reset)
        done |=> !done;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("done held past one cycle");

    property p_we_stable;
        @(posedge clk_sys) disable iff (reset)
        periph_cycle_out && $past(periph_cycle_out) |-> $stable(periph_write_flag);
    endproperty
    a_we_stable: assert property (p_we_stable)
        else $error("write flag changed in cycle");

    property p_sel_stable;
        @(posedge clk_sys) disable iff (reset)
        periph_cycle_out && $past(periph_cycle_out) |-> $stable(periph_byte_select);
    endproperty
    a_sel_stable: assert property (p_sel_stable)
        else $error("select changed in cycle");

    property p_sel_word;
        @(posedge clk_sys) disable iff (reset)
        start && req.size == size_word |=> periph_byte_select == `SEL_WORD;
    endproperty
    a_sel_word: assert property (p_sel_word)
        else $error("word select wrong");

    property p_sel_half;
        @(posedge clk_sys) disable iff (reset)
        start && req.size == size_half |=>
            periph_byte_select == ($past(req.addr[1]) ? `SEL_HALF_HI : `SEL_HALF_LO);
    endproperty
    a_sel_half: assert property (p_sel_half)
        else $error("half select wrong");

    property p_sel_byte;
        @(posedge clk_sys) disable iff (reset)
        start && req.size == size_byte |=> $onehot(periph_byte_select);
    endproperty
    a_sel_byte: assert property (p_sel_byte)
        else $error("byte select not one lane");

    property p_sel_bad;
        @(posedge clk_sys) disable iff (reset)
        start && req.size == size_bad |=> periph_byte_select == `SEL_NONE;
    endproperty
    a_sel_bad: assert property (p_sel_bad)
        else $error("bad size selected lanes");

    property p_we_src;
        @(posedge clk_sys) disable iff (reset)
        start |=> periph_write_flag == $past(req.write);
    endproperty
    a_we_src: assert property (p_we_src)
        else $error("write flag mismatch");

    property p_rdata_read;
        @(posedge clk_sys) disable iff (reset)
        ack_taken && !periph_write_flag |=> rdata == $past(periph_read_data);
    endproperty
    a_rdata_read: assert property (p_rdata_read)
        else $error("read data not taken on ack");

    property p_rst_rel;
        @(posedge clk_sys)
        !reset && !$past(reset) |-> !periph_reset_out;
    endproperty
    a_rst_rel: assert property (p_rst_rel)
        else $error("forwarded reset stuck");

    property p_ready_rst;
        @(posedge clk_sys) disable iff (reset)
        periph_reset_out |-> !req_ready;
    endproperty
    a_ready_rst: assert property (p_ready_rst)
        else $error("request taken in forwarded reset");

    property p_rst_on;
        @(posedge clk_sys)
        reset |-> periph_reset_out;
    endproperty
    a_rst_on: assert property (p_rst_on)
        else $error("forwarded reset low in reset");

    property p_halt;
        @(posedge clk_sys) disable iff (reset)
        armed_r && breakpoint_hit |=> halted == BREAK_ON_HARD_RESET;
    endproperty
    a_halt: assert property (p_halt)
        else $error("halt option ignored");
endmodule // periph_port_side

// ==== periph_port_map.svh ====
// constants for the peripheral port sideband block
`ifndef PERIPH_PORT_MAP_SVH
`define PERIPH_PORT_MAP_SVH
`define SEL_NONE      4'h0
`define SEL_WORD      4'hf
`define SEL_HALF_LO   4'h3
`define SEL_HALF_HI   4'hc
`define SEL_BYTE_ONE  4'h1
`define SIZE_BYTE     2'h0
`define SIZE_HALF     2'h1
`define SIZE_WORD     2'h2
`endif

// ==== periph_port_pkg.sv ====
// types for the peripheral port sideband block
package periph_port_pkg;
    typedef enum logic [1:0] {
        size_byte,
        size_half,
        size_word,
        size_bad
    } acc_size_e;

    // one access request from the core
    typedef struct packed {
        logic        write;
        acc_size_e   size;
        logic [23:0] addr;
        logic [31:0] wdata;
    } periph_req_s;
endpackage

// ==== periph_slave_model.sv ====
// behavioural peripheral slave with adjustable acknowledge delay
`timescale 1ns/1ps
module periph_slave_model (
    input  wire logic        clk,
    input  wire logic        cyc,
    input  wire logic [3:0]  sel,
    input  wire logic        we,
    input  wire logic [31:0] wdata,
    input  wire logic [1:0]  delay,
    output logic             ack,
    output logic [31:0]      rdata
);
    logic [31:0] mem_r;
    logic [1:0]  cnt_r;
    wire         fin = cyc && !ack && cnt_r == delay;
    // one ack pulse per cycle, lanes written only where selected
    always_ff @(posedge clk) begin
        cnt_r <= (cyc && !ack) ? cnt_r + 2'h1 : 2'h0;
        ack <= fin;
        for (int i = 0; i < 4; i++)
            if (fin && we && sel[i]) mem_r[8*i+:8] <= wdata[8*i+:8];
    end
    // released data lines show the inverse
    assign rdata = cyc ? mem_r : ~mem_r;
endmodule // periph_slave_model

// ==== wishbone_periph_port_sideband_tb.sv ====
// self-checking bench for the peripheral port sideband block
`timescale 1ns/1ps
module wishbone_periph_port_sideband_tb;
    import periph_port_pkg::*;
    logic clk_sys = 0, reset = 0, req_valid = 0, breakpoint_hit = 0;
    logic ack, ready, done, halted, mdp, pclk, prst, cyc, we, stb;
    logic [1:0] delay = 2'h0;
    logic [3:0] sel;
    logic [23:0] addr;
    logic [31:0] rdata, wd, rd;
    periph_req_s req = '0;
    int miscompares = 0, checks = 0;
    periph_port_side #(.BREAK_ON_HARD_RESET(1'b1), .HAS_MULDIV_UNIT(1'b0)) dut_u (
        .clk_sys(clk_sys), .reset(reset), .req(req), .req_valid(req_valid),
        .req_ready(ready), .done(done), .rdata(rdata), .breakpoint_hit(breakpoint_hit),
        .halted(halted), .muldiv_present(mdp), .periph_clock_out(pclk),
        .periph_reset_out(prst), .periph_cycle_out(cyc), .periph_strobe_out(stb),
        .periph_addr_out(addr), .periph_write_data(wd), .periph_byte_select(sel),
        .periph_write_flag(we), .periph_ack_in(ack), .periph_read_data(rd));
    periph_slave_model slave_u (.clk(pclk), .cyc(cyc), .sel(sel), .we(we),
        .wdata(wd), .delay(delay), .ack(ack), .rdata(rd));
    // clock
    always #2.5 clk_sys = ~clk_sys;
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic access(logic w, acc_size_e sz, logic [23:0] a, logic [31:0] d,
                          logic [3:0] es);
        int n;
        n = 0;
        @(posedge clk_sys);
        req <= '{w, sz, a, d};
        req_valid <= 1'b1;
        @(negedge clk_sys);
        while (ready !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        @(posedge clk_sys);
        req_valid <= 1'b0;
        @(negedge clk_sys);
        chk("select", es, sel);
        chk("write_flag", w, we);
        chk("addr", a, addr);
        chk("wdata", d, wd);
        while (done !== 1'b1 && n < 20) begin
            chk("cycle", 1, cyc);
            chk("strobe", 1, stb);
            @(negedge clk_sys);
            n++;
        end
        if (n >= 20) begin
            miscompares++;
            close_out();
        end
        chk("cycle_end", 0, cyc);
    endtask
    task automatic t_reset();
        @(negedge clk_sys);
        chk("reset_out", 1, prst);
        chk("muldiv", 0, mdp);
        chk("cycle_rst", 0, cyc);
        @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk("reset_low", 0, prst);
        chk("clock_low", clk_sys, pclk);
        @(posedge clk_sys);
        #1 chk("clock_high", 1, pclk);
        $display("test reset ended");
    endtask
    task automatic t_lanes();
        access(1, size_word, 24'h10, 32'h11223344, 4'hf);
        access(1, size_byte, 24'h11, 32'h0000aa00, 4'h2);
        access(1, size_half, 24'h12, 32'hbbcc0000, 4'hc);
        access(1, size_byte, 24'h13, 32'h99000000, 4'h8);
        delay <= 2'h3;
        access(1, size_byte, 24'h10, 32'h000000dd, 4'h1);
        access(0, size_half, 24'h10, 32'h0, 4'h3);
        chk("read_word", 32'h99ccaadd, rdata);
        access(0, size_bad, 24'h10, 32'h0, 4'h0);
        $display("test lanes ended");
    endtask
    task automatic t_halt();
        chk("halted_idle", 0, halted);
        @(posedge clk_sys);
        breakpoint_hit <= 1'b1;
        @(posedge clk_sys);
        breakpoint_hit <= 1'b0;
        @(negedge clk_sys);
        chk("halted", 1, halted);
        @(posedge clk_sys);
        reset <= 1'b1;
        #1 chk("halt_clear", 0, halted);
        chk("reset_again", 1, prst);
        @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk("release_again", 0, prst);
        $display("test halt ended");
    endtask
    initial begin
        reset <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_lanes();
        t_halt();
        close_out();
    end
endmodule // wishbone_periph_port_sideband_tb
